// [core/operand_timing_pkg.sv]
// Shared types and constants for operand addressing and execution timing.
package operand_timing_pkg;

	localparam int          DATA_W       = 16;
	localparam int          ACC_W        = 40;
	localparam int          NUM_WREGS    = 16;
	localparam int          SHADOW_CNT   = 4;
	localparam logic [15:0] NEAR_MASK    = 16'h1FFF;
	localparam logic [15:0] WORD_MASK    = 16'hFFFE;
	localparam logic [3:0]  DEFAULT_DEFAULT_WORK_REG = 4'h0;
	localparam logic [3:0]  STACK_PTR    = 4'hF;
	localparam logic [15:0] STACK_STEP   = 16'h0002;
	localparam logic [15:0] STACK_PAIR   = 16'h0004;
	localparam logic [1:0]  CYC_ONE      = 2'h1;
	localparam logic [1:0]  CYC_TWO      = 2'h2;
	localparam logic [1:0]  CYC_THREE    = 2'h3;
	localparam logic [14:0] HOLD_ZERO    = 15'h0000;
	localparam logic [16:0] REPEAT_ZERO  = 17'h00000;

	typedef enum logic [4:0] {
		OP_NOP       = 5'h00,
		OP_FILE_ALU  = 5'h01,
		OP_FILE_LOAD = 5'h02,
		OP_FILE_STORE = 5'h03,
		OP_REG_ALU   = 5'h04,
		OP_BRA_COND  = 5'h05,
		OP_SKIP      = 5'h06,
		OP_RETURN    = 5'h07,
		OP_PUSH_D    = 5'h08,
		OP_POP_D     = 5'h09,
		OP_PUSH_S    = 5'h0A,
		OP_POP_S     = 5'h0B,
		OP_HOLD      = 5'h0C,
		OP_ACC_SHIFT = 5'h0D,
		OP_ACC_ADD   = 5'h0E,
		OP_NEG_PROD  = 5'h0F,
		OP_REPEAT    = 5'h10,
		OP_DO        = 5'h11
	} op_t;

	typedef enum logic [1:0] {
		ALU_ADD = 2'h0,
		ALU_AND = 2'h1,
		ALU_IOR = 2'h2,
		ALU_XOR = 2'h3
	} alu_t;

	typedef enum logic [1:0] {
		SRC_DIRECT   = 2'h0,
		SRC_INDIRECT = 2'h1,
		SRC_IMM      = 2'h2
	} src_t;

	typedef struct packed {
		op_t         op;
		alu_t        aluOp;
		logic        byteMode;
		logic        toWreg;
		src_t        srcMode;
		logic [3:0]  wa;
		logic [3:0]  wb;
		logic [3:0]  wd;
		logic [15:0] fileAddr;
		logic [15:0] imm;
		logic [13:0] countLit;
		logic [5:0]  shiftLit6;
		logic [3:0]  shiftLit4;
		logic        accSel;
		logic        condTrue;
		logic        skipTwoWord;
		logic        excPending;
	} instr_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        byteMode;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

endpackage

// [core/acc_shifter.sv]
// Arithmetic shifter for accumulators; positive amounts shift right.
`timescale 1ns/1ps

module acc_shifter #(
	parameter int WIDTH = 40
) (
	// Data.
	input  wire logic signed [WIDTH-1:0] din,
	input  wire logic signed [5:0]       amount,
	output logic signed [WIDTH-1:0]      dout
);

	logic [5:0] mag;

	always_comb begin
		mag = amount[5] ? 6'(-amount) : 6'(amount);
		if (amount[5]) begin
			dout = din <<< mag;
		end else begin
			dout = din >>> mag;
		end
	end

endmodule

// [core/operand_addressing_and_timing.sv]
// Operand address generation, result routing and execution timing core.
`timescale 1ns/1ps

module operand_addressing_and_timing
	import operand_timing_pkg::*;
#(
	parameter int NUM_SHADOW = operand_timing_pkg::SHADOW_CNT
) (
	// Clock and reset.
	input  wire logic                           clk,
	input  wire logic                           rst,
	// Instruction issue.
	input  wire logic                           instrValid,
	input  wire operand_timing_pkg::instr_t     instrIn,
	output logic                                ready,
	output logic                                done,
	output logic                                redirect,
	// Data memory.
	output operand_timing_pkg::mem_req_t        memReq,
	input  wire logic [15:0]                    memRdata,
	// Interrupt hold and loop control.
	output logic                                irqBlocked,
	output logic                                loopLoad,
	output logic                                loopIsDo,
	output logic [16:0]                         loopTimes,
	// Observation.
	input  wire logic [3:0]                     viewSel,
	output logic [15:0]                         viewData,
	output logic signed [39:0]                  accA,
	output logic signed [39:0]                  accB
);

	import operand_timing_pkg::*;

	logic [15:0]        default_work_reg_q [NUM_WREGS];
	logic [15:0]        default_work_reg_d [NUM_WREGS];
	logic [15:0]        shadow_q [NUM_SHADOW];
	logic [15:0]        shadow_d [NUM_SHADOW];
	instr_t             cur_q, cur_d;
	logic [1:0]         step_q, step_d, last_q, last_d;
	logic               ready_q, ready_d, done_q, done_d;
	logic               redirect_q, redirect_d;
	mem_req_t           memReq_q, memReq_d;
	logic [14:0]        hold_q, hold_d;
	logic               irqBlocked_q, irqBlocked_d;
	logic               loopLoad_q, loopLoad_d, loopIsDo_q, loopIsDo_d;
	logic [16:0]        loopTimes_q, loopTimes_d;
	logic [15:0]        viewData_q, viewData_d;
	logic signed [39:0] acc_q [2];
	logic signed [39:0] acc_d [2];
	logic signed [39:0] shiftOut, addOut, addIn;
	logic [15:0]        memByte, srcVal, aluRes, fileWord;
	logic [31:0]        product;

	// Execution length of each instruction.
	function automatic logic [1:0] cyclesFor(input instr_t i);
		logic [1:0] c;
		c = CYC_ONE;
		unique case (i.op)
			OP_BRA_COND: c = i.condTrue ? CYC_TWO : CYC_ONE;
			OP_RETURN:   c = i.excPending ? CYC_TWO : CYC_THREE;
			OP_PUSH_D,
			OP_POP_D:    c = CYC_TWO;
			OP_SKIP: begin
				if (!i.condTrue) begin
					c = CYC_ONE;
				end else begin
					c = i.skipTwoWord ? CYC_THREE : CYC_TWO;
				end
			end
			default:     c = CYC_ONE;
		endcase
		return c;
	endfunction

	// Memory request for a given step of an instruction.
	function automatic mem_req_t reqFor(input instr_t i, input logic [1:0] s,
		input logic [15:0] w [NUM_WREGS]);
		mem_req_t r;
		r = '0;
		unique case (i.op)
			OP_FILE_ALU: begin
				r.valid    = 1'b1;
				r.byteMode = i.byteMode;
				r.addr     = i.fileAddr & NEAR_MASK;
			end
			OP_FILE_LOAD: begin
				r.valid = 1'b1;
				r.addr  = i.fileAddr & WORD_MASK;
			end
			OP_FILE_STORE: begin
				r.valid = 1'b1;
				r.write = 1'b1;
				r.addr  = i.fileAddr & WORD_MASK;
				r.wdata = w[i.wa];
			end
			OP_REG_ALU, OP_ACC_ADD: begin
				if (i.srcMode == SRC_INDIRECT) begin
					r.valid    = 1'b1;
					r.byteMode = i.byteMode & (i.op == OP_REG_ALU);
					r.addr     = w[i.wb];
				end
			end
			OP_PUSH_D: begin
				r.valid = 1'b1;
				r.write = 1'b1;
				r.addr  = (s == 2'h0) ? w[STACK_PTR] : w[STACK_PTR] + STACK_STEP;
				r.wdata = (s == 2'h0) ? w[i.wa] : w[4'(i.wa + 4'h1)];
			end
			OP_POP_D: begin
				r.valid = 1'b1;
				r.addr  = (s == 2'h0) ? w[STACK_PTR] - STACK_STEP
					: w[STACK_PTR] - STACK_PAIR;
			end
			default: r = '0;
		endcase
		if (r.write && r.byteMode) begin
			r.wdata = {r.wdata[7:0], r.wdata[7:0]};
		end
		return r;
	endfunction

	// Byte lane of the returned word and the operand value.
	always_comb begin
		memByte  = memReq_q.addr[0] ? {8'h00, memRdata[15:8]}
			: {8'h00, memRdata[7:0]};
		fileWord = memReq_q.byteMode ? memByte : memRdata;
		unique case (cur_q.srcMode)
			SRC_INDIRECT: srcVal = fileWord;
			SRC_IMM:      srcVal = cur_q.imm;
			default:      srcVal = default_work_reg_q[cur_q.wb];
		endcase
		if (cur_q.op == OP_FILE_ALU) begin
			srcVal = fileWord;
		end
	end

	// Small ALU shared by file and register forms.
	always_comb begin
		logic [15:0] a;
		a = (cur_q.op == OP_FILE_ALU) ? default_work_reg_q[DEFAULT_DEFAULT_WORK_REG]
			: default_work_reg_q[cur_q.wa];
		unique case (cur_q.aluOp)
			ALU_ADD: aluRes = a + srcVal;
			ALU_AND: aluRes = a & srcVal;
			ALU_IOR: aluRes = a | srcVal;
			ALU_XOR: aluRes = a ^ srcVal;
		endcase
	end

	assign addIn   = {{8{srcVal[15]}}, srcVal, 16'h0000};
	assign product = 32'($signed(default_work_reg_q[cur_q.wa]) * $signed(default_work_reg_q[cur_q.wb]));

	acc_shifter #(
		.WIDTH (ACC_W)
	) u_lit_shift (
		.din    (acc_q[cur_q.accSel]),
		.amount (cur_q.shiftLit6),
		.dout   (shiftOut)
	);

	acc_shifter #(
		.WIDTH (ACC_W)
	) u_add_shift (
		.din    (addIn),
		.amount ({{2{cur_q.shiftLit4[3]}}, cur_q.shiftLit4}),
		.dout   (addOut)
	);

	// Sequencing, operand routing and result write-back.
	always_comb begin
		logic       fin;
		logic [3:0] dst;
		logic [15:0] res;
		fin          = 1'b0;
		dst          = cur_q.wd;
		res          = aluRes;
		default_work_reg_d       = default_work_reg_q;
		shadow_d     = shadow_q;
		acc_d        = acc_q;
		cur_d        = cur_q;
		step_d       = step_q;
		last_d       = last_q;
		ready_d      = ready_q;
		done_d       = 1'b0;
		redirect_d   = 1'b0;
		memReq_d     = memReq_q;
		loopLoad_d   = 1'b0;
		loopIsDo_d   = loopIsDo_q;
		loopTimes_d  = loopTimes_q;
		hold_d       = (hold_q != HOLD_ZERO) ? hold_q - 15'h0001 : HOLD_ZERO;
		viewData_d   = default_work_reg_q[viewSel];
		if (ready_q) begin
			if (instrValid) begin
				cur_d    = instrIn;
				step_d   = 2'h0;
				last_d   = cyclesFor(instrIn) - 2'h1;
				ready_d  = 1'b0;
				memReq_d = reqFor(instrIn, 2'h0, default_work_reg_q);
			end
		end else begin
			fin = (step_q == last_q);
			if (!fin) begin
				step_d   = step_q + 2'h1;
				memReq_d = reqFor(cur_q, step_q + 2'h1, default_work_reg_q);
			end else begin
				ready_d  = 1'b1;
				done_d   = 1'b1;
				memReq_d = '0;
			end
			unique case (cur_q.op)
				OP_FILE_ALU: begin
					if (fin && cur_q.toWreg) begin
						dst = DEFAULT_DEFAULT_WORK_REG;
					end else begin
						dst = STACK_PTR;
						fin = 1'b0;
						if (step_q == last_q) begin
							memReq_d.valid    = 1'b1;
							memReq_d.write    = 1'b1;
							memReq_d.byteMode = cur_q.byteMode;
							memReq_d.addr     = memReq_q.addr;
							memReq_d.wdata    = cur_q.byteMode
								? {aluRes[7:0], aluRes[7:0]} : aluRes;
							ready_d           = 1'b0;
							done_d            = 1'b0;
							cur_d.op          = OP_NOP;
						end
					end
				end
				OP_FILE_LOAD: begin
					dst = cur_q.wa;
					res = memRdata;
				end
				OP_REG_ALU: begin
					dst = cur_q.wd;
				end
				OP_BRA_COND, OP_RETURN: begin
					redirect_d = fin & (cur_q.condTrue | (cur_q.op == OP_RETURN));
					fin        = 1'b0;
				end
				OP_SKIP: begin
					redirect_d = fin & cur_q.condTrue;
					fin        = 1'b0;
				end
				OP_POP_D: begin
					if (step_q == 2'h0) begin
						default_work_reg_d[4'(cur_q.wa + 4'h1)] = memRdata;
					end else begin
						default_work_reg_d[cur_q.wa] = memRdata;
						default_work_reg_d[STACK_PTR] = default_work_reg_q[STACK_PTR] - STACK_PAIR;
					end
					fin = 1'b0;
				end
				OP_PUSH_D: begin
					if (fin) begin
						default_work_reg_d[STACK_PTR] = default_work_reg_q[STACK_PTR] + STACK_PAIR;
					end
					fin = 1'b0;
				end
				OP_PUSH_S: begin
					for (int k = 0; k < NUM_SHADOW; k++) begin
						shadow_d[k] = default_work_reg_q[k];
					end
					fin = 1'b0;
				end
				OP_POP_S: begin
					for (int k = 0; k < NUM_SHADOW; k++) begin
						default_work_reg_d[k] = shadow_q[k];
					end
					fin = 1'b0;
				end
				OP_HOLD: begin
					hold_d = {1'b0, cur_q.countLit} + 15'h0001;
					fin    = 1'b0;
				end
				OP_ACC_SHIFT: begin
					acc_d[cur_q.accSel] = shiftOut;
					fin = 1'b0;
				end
				OP_ACC_ADD: begin
					acc_d[cur_q.accSel] = acc_q[cur_q.accSel] + addOut;
					fin = 1'b0;
				end
				OP_NEG_PROD: begin
					acc_d[cur_q.accSel] = -{{8{product[31]}}, product};
					fin = 1'b0;
				end
				OP_REPEAT, OP_DO: begin
					loopLoad_d  = 1'b1;
					loopIsDo_d  = (cur_q.op == OP_DO);
					loopTimes_d = (cur_q.srcMode == SRC_DIRECT)
						? {1'b0, default_work_reg_q[cur_q.wb]} + 17'h00001
						: {3'b000, cur_q.countLit} + 17'h00001;
					fin = 1'b0;
				end
				default: fin = 1'b0;
			endcase
			if (fin) begin
				if (cur_q.byteMode && cur_q.op != OP_FILE_LOAD) begin
					default_work_reg_d[dst] = {default_work_reg_q[dst][15:8], res[7:0]};
				end else begin
					default_work_reg_d[dst] = res;
				end
			end
		end
		irqBlocked_d = (hold_d != HOLD_ZERO);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int k = 0; k < NUM_WREGS; k++) begin
				default_work_reg_q[k] <= 16'h0000;
			end
			for (int k = 0; k < NUM_SHADOW; k++) begin
				shadow_q[k] <= 16'h0000;
			end
			acc_q[0]     <= '0;
			acc_q[1]     <= '0;
			cur_q        <= '0;
			step_q       <= 2'h0;
			last_q       <= 2'h0;
			ready_q      <= 1'b1;
			done_q       <= 1'b0;
			redirect_q   <= 1'b0;
			memReq_q     <= '0;
			hold_q       <= HOLD_ZERO;
			irqBlocked_q <= 1'b0;
			loopLoad_q   <= 1'b0;
			loopIsDo_q   <= 1'b0;
			loopTimes_q  <= REPEAT_ZERO;
			viewData_q   <= 16'h0000;
		end else begin
			default_work_reg_q       <= default_work_reg_d;
			shadow_q     <= shadow_d;
			acc_q        <= acc_d;
			cur_q        <= cur_d;
			step_q       <= step_d;
			last_q       <= last_d;
			ready_q      <= ready_d;
			done_q       <= done_d;
			redirect_q   <= redirect_d;
			memReq_q     <= memReq_d;
			hold_q       <= hold_d;
			irqBlocked_q <= irqBlocked_d;
			loopLoad_q   <= loopLoad_d;
			loopIsDo_q   <= loopIsDo_d;
			loopTimes_q  <= loopTimes_d;
			viewData_q   <= viewData_d;
		end
	end

	assign ready      = ready_q;
	assign done       = done_q;
	assign redirect   = redirect_q;
	assign memReq     = memReq_q;
	assign irqBlocked = irqBlocked_q;
	assign loopLoad   = loopLoad_q;
	assign loopIsDo   = loopIsDo_q;
	assign loopTimes  = loopTimes_q;
	assign viewData   = viewData_q;
	assign accA       = acc_q[0];
	assign accB       = acc_q[1];

endmodule

// [test/data_mem_model.sv]
// Data memory model that answers core requests in the same cycle.
`timescale 1ns/1ps

module data_mem_model
	import operand_timing_pkg::*;
(
	// Clock and request.
	input  wire logic                        clk,
	input  wire operand_timing_pkg::mem_req_t memReq,
	// Answer.
	output logic [15:0]                      memRdata
);
	logic [15:0] mem [32768];
	logic [15:0] k;
	// Idle cycles show the inverse of the last word read.
	assign memRdata = memReq.valid ? mem[memReq.addr[15:1]] : ~k;
	initial begin
		foreach (mem[j]) mem[j] = 16'h0000;
		k = 16'h0000;
	end
	always @(posedge clk) begin
		if (memReq.valid) begin
			k <= mem[memReq.addr[15:1]];
			if (memReq.write && !memReq.byteMode) begin
				mem[memReq.addr[15:1]] <= memReq.wdata;
			end else if (memReq.write && memReq.addr[0]) begin
				mem[memReq.addr[15:1]][15:8] <= memReq.wdata[15:8];
			end else if (memReq.write) begin
				mem[memReq.addr[15:1]][7:0] <= memReq.wdata[7:0];
			end
		end
	end
endmodule

// [test/operand_timing_properties.sv]
// Timing and addressing checks bound to the operand core.
`timescale 1ns/1ps

module operand_timing_properties
	import operand_timing_pkg::*;
(
	input wire logic                          clk,
	input wire logic                          rst,
	input wire logic                          instrValid,
	input wire operand_timing_pkg::instr_t   instrIn,
	input wire logic                          ready,
	input wire logic                          done,
	input wire logic                          redirect,
	input wire operand_timing_pkg::mem_req_t memReq,
	input wire logic                          irqBlocked
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic   tk;
	instr_t i;
	assign tk = ready && instrValid;
	assign i = instrIn;
	property p_bra;
		tk && i.op == OP_BRA_COND && i.condTrue
		|=> (!ready) [*2] ##1 done && redirect;
	endproperty
	a_bra: assert property (p_bra) else $error("Taken branch timing");
	property p_ret;
		tk && i.op == OP_RETURN && !i.excPending |=> (!ready) [*3] ##1 done;
	endproperty
	a_ret: assert property (p_ret) else $error("Return timing");
	property p_skip;
		tk && i.op == OP_SKIP && i.condTrue && i.skipTwoWord
		|=> (!ready) [*3] ##1 done && redirect;
	endproperty
	a_skip: assert property (p_skip) else $error("Long skip timing");
	property p_pushd;
		tk && i.op == OP_PUSH_D
		|=> (memReq.valid && memReq.write) [*2] ##1 done;
	endproperty
	a_pushd: assert property (p_pushd) else $error("Pair push");
	property p_hold;
		tk && i.op == OP_HOLD |=> !ready ##1 done ##[0:1] irqBlocked;
	endproperty
	a_hold: assert property (p_hold) else $error("Hold block");
	property p_near;
		tk && i.op == OP_FILE_ALU |=> memReq.valid && !memReq.write
		&& memReq.addr == ($past(i.fileAddr) & NEAR_MASK);
	endproperty
	a_near: assert property (p_near) else $error("Near address");
	property p_load;
		tk && i.op == OP_FILE_LOAD |=> memReq.valid && !memReq.byteMode
		&& memReq.addr == ($past(i.fileAddr) & WORD_MASK);
	endproperty
	a_load: assert property (p_load) else $error("File move word");
	property p_imm;
		tk && i.op == OP_REG_ALU && i.srcMode == SRC_IMM
		|=> (!memReq.valid) [*2];
	endproperty
	a_imm: assert property (p_imm) else $error("Immediate access");
endmodule

bind operand_addressing_and_timing operand_timing_properties u_prop (
	.clk(clk), .rst(rst), .instrValid(instrValid), .instrIn(instrIn),
	.ready(ready), .done(done), .redirect(redirect), .memReq(memReq),
	.irqBlocked(irqBlocked)
);

// [test/testbench.sv]
// Self-checking bench for the operand addressing and timing core.
`timescale 1ns/1ps

module testbench;
	import operand_timing_pkg::*;
	typedef struct packed {
		op_t        op;
		logic [2:0] f;
		logic [3:0] n;
		logic       r;
	} row_t;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               instrValid = 1'b0;
	instr_t             instrIn = '0;
	instr_t             t;
	logic [3:0]         viewSel = 4'h0;
	logic               ready, done, redirect, irqBlocked, loopLoad, loopIsDo;
	logic [16:0]        loopTimes;
	logic [15:0]        memRdata, viewData;
	logic signed [39:0] accA, accB;
	mem_req_t           memReq;
	int                 bad_count = 0;
	int                 n_tests = 0;
	int                 n;
	logic               r;
	row_t               rows [12];

	operand_addressing_and_timing u_dut (
		.clk(clk), .rst(rst), .instrValid(instrValid), .instrIn(instrIn),
		.ready(ready), .done(done), .redirect(redirect), .memReq(memReq),
		.memRdata(memRdata), .irqBlocked(irqBlocked), .loopLoad(loopLoad),
		.loopIsDo(loopIsDo), .loopTimes(loopTimes), .viewSel(viewSel),
		.viewData(viewData), .accA(accA), .accB(accB)
	);
	data_mem_model u_mem (.clk(clk), .memReq(memReq), .memRdata(memRdata));

	task automatic chk(input logic [39:0] s, input logic [39:0] x);
		n_tests++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, s, x);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic instr_t mk(input op_t o, input logic [11:0] abd);
		mk = '0;
		mk.op = o;
		{mk.wa, mk.wb, mk.wd} = abd;
	endfunction
	// Issues t at a falling edge and counts cycles until done shows.
	task automatic ex();
		instrIn = t;
		instrValid = 1'b1;
		@(negedge clk);
		instrValid = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 9) begin
			@(negedge clk);
			n++;
		end
		r = redirect;
		if (n >= 9) begin
			bad_count++;
			$display("BAD %0t no completion", $time);
			print_verdict();
		end
	endtask
	task automatic cw(input logic [3:0] a, input logic [15:0] x);
		viewSel = a;
		@(negedge clk);
		@(negedge clk);
		chk(viewData, x);
	endtask

	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		rows = '{'{OP_BRA_COND, 3'h0, 4'h2, 1'b0}, '{OP_BRA_COND, 3'h4, 4'h3, 1'b1},
			'{OP_RETURN, 3'h0, 4'h4, 1'b1}, '{OP_RETURN, 3'h2, 4'h3, 1'b1},
			'{OP_SKIP, 3'h0, 4'h2, 1'b0}, '{OP_SKIP, 3'h1, 4'h2, 1'b0},
			'{OP_SKIP, 3'h4, 4'h3, 1'b1}, '{OP_SKIP, 3'h5, 4'h4, 1'b1},
			'{OP_PUSH_S, 3'h0, 4'h2, 1'b0}, '{OP_POP_S, 3'h0, 4'h2, 1'b0},
			'{OP_HOLD, 3'h0, 4'h2, 1'b0}, '{OP_NOP, 3'h0, 4'h2, 1'b0}};
		repeat (3) @(negedge clk);
		rst = 1'b0;
		u_mem.mem[16'h0400] = 16'h332C;
		u_mem.mem[16'h0800] = 16'h5555;
		u_mem.mem[16'h7800] = 16'hBEEF;
		foreach (rows[k]) begin
			t = mk(rows[k].op, 12'h000);
			{t.condTrue, t.excPending, t.skipTwoWord} = rows[k].f;
			ex();
			chk(40'({n[3:0], r}), 40'({rows[k].n, rows[k].r}));
		end
		$display("Timing table done");
		t = mk(OP_FILE_LOAD, 12'h000);
		t.fileAddr = 16'h0800;
		ex();
		t = mk(OP_FILE_LOAD, 12'h100);
		t.fileAddr = 16'hF001;
		ex();
		cw(4'h1, 16'hBEEF);
		t = mk(OP_FILE_ALU, 12'h000);
		t.aluOp = ALU_AND;
		t.fileAddr = 16'h5000;
		ex();
		chk(40'(n), 40'h3);
		chk(u_mem.mem[16'h0800], 16'h1104);
		t.aluOp = ALU_XOR;
		t.toWreg = 1'b1;
		ex();
		cw(4'h0, 16'h2228);
		chk(u_mem.mem[16'h0800], 16'h1104);
		t = mk(OP_FILE_STORE, 12'h100);
		t.fileAddr = 16'hF002;
		ex();
		chk(u_mem.mem[16'h7801], 16'hBEEF);
		t = mk(OP_REG_ALU, 12'h000);
		t.aluOp = ALU_IOR;
		t.byteMode = 1'b1;
		t.srcMode = SRC_IMM;
		t.imm = 16'h0044;
		ex();
		cw(4'h0, 16'h226C);
		t = mk(OP_REG_ALU, 12'h302);
		t.srcMode = SRC_IMM;
		t.imm = 16'hF002;
		ex();
		t.imm = 16'h0900;
		t.wd = 4'hF;
		ex();
		t = mk(OP_REG_ALU, 12'h324);
		t.aluOp = ALU_XOR;
		t.srcMode = SRC_INDIRECT;
		ex();
		cw(4'h4, 16'hBEEF);
		t = mk(OP_PUSH_D, 12'h111);
		ex();
		chk({u_mem.mem[16'h0480], u_mem.mem[16'h0481]}, 32'hBEEFF002);
		t = mk(OP_POP_D, 12'h555);
		ex();
		cw(4'h6, 16'hF002);
		cw(4'hF, 16'h0900);
		$display("Addressing done");
		t = mk(OP_REPEAT, 12'h020);
		ex();
		chk({loopLoad, loopIsDo, loopTimes}, {2'h2, 17'h0F003});
		t = mk(OP_DO, 12'h000);
		t.srcMode = SRC_IMM;
		t.countLit = 14'h3FFF;
		ex();
		chk({loopLoad, loopIsDo, loopTimes}, {2'h3, 17'h04000});
		t = mk(OP_HOLD, 12'h000);
		t.countLit = 14'h0003;
		ex();
		n = 0;
		repeat (8) begin
			if (irqBlocked === 1'b1) n++;
			@(negedge clk);
		end
		chk(40'(n), 40'h4);
		t = mk(OP_NEG_PROD, 12'h120);
		ex();
		chk(accA, -(40'h4111 * 40'h0FFE));
		t = mk(OP_ACC_SHIFT, 12'h000);
		t.shiftLit6 = 6'h3C;
		ex();
		chk(accA, -(40'h4111 * 40'h0FFE * 40'h10));
		t = mk(OP_ACC_ADD, 12'h010);
		t.accSel = 1'b1;
		t.shiftLit4 = 4'h1;
		ex();
		chk(accB, 40'hFFDF778000);
		t = mk(OP_PUSH_S, 12'h000);
		ex();
		t = mk(OP_REG_ALU, 12'h300);
		t.srcMode = SRC_IMM;
		ex();
		t = mk(OP_POP_S, 12'h000);
		ex();
		cw(4'h0, 16'h226C);
		$display("Loop, hold and accumulator done");
		t = mk(OP_PUSH_D, 12'h111);
		instrIn = t;
		instrValid = 1'b1;
		@(negedge clk);
		instrValid = 1'b0;
		rst = 1'b1;
		@(negedge clk);
		chk({ready, done, memReq.valid, irqBlocked}, 4'h8);
		rst = 1'b0;
		t = mk(OP_BRA_COND, 12'h000);
		t.condTrue = 1'b1;
		ex();
		chk(40'({n[3:0], r}), 40'({4'h3, 1'b1}));
		cw(4'hF, 16'h0000);
		chk(accA, 40'h0);
		$display("Reset done");
		print_verdict();
	end
endmodule
